// File: core/tpp_timer.sv
// Timer core: counter, compare buffering, flags and register port
//
// Local design decisions: the address map and the plain strobed port.
`default_nettype none
module tpp_timer #(
	parameter int ADDR_W = 3
) (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              timerTick,
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [7:0]        regWdata,
	input  wire logic              regWrite,
	input  wire logic              regRead,
	output logic      [7:0]        regRdata,
	input  wire logic              portDirA,
	input  wire logic              portDirB,
	output logic                   waveOutA,
	output logic                   waveOutB,
	output logic                   overrideA,
	output logic                   overrideB,
	output logic                   pinOeA,
	output logic                   pinOeB,
	output logic                   overflowFlag,
	output logic                   matchAFlag,
	output logic                   matchBFlag
);
	import tpp_pkg::*;

	if (ADDR_W < 3) begin : gAddrCheck
		$error("ADDR_W too small for the register map");
	end

	logic [7:0] ctrlA_reg;
	logic       modeHi_reg;
	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic       countDown_reg;
	logic       countDown_next;
	logic       block_reg;
	logic [7:0] cmpABuf_reg;
	logic [7:0] cmpBBuf_reg;
	logic [7:0] cmpAAct_reg;
	logic [7:0] cmpBAct_reg;
	logic [2:0] flags_reg;
	logic [2:0] flags_next;
	logic [7:0] rdata_reg;
	logic       oeA_reg;
	logic       oeB_reg;

	// Register decode
	logic       selLow;
	logic       wrCtrlA;
	logic       wrCtrlB;
	logic       wrCount;
	logic       wrCmpA;
	logic       wrCmpB;
	logic       wrFlags;
	logic [7:0] rdNext;

	assign selLow  = (regAddr >> 3) == '0;
	assign wrCtrlA = regWrite && selLow && regAddr[2:0] == REG_CTRL_A;
	assign wrCtrlB = regWrite && selLow && regAddr[2:0] == REG_CTRL_B;
	assign wrCount = regWrite && selLow && regAddr[2:0] == REG_COUNT;
	assign wrCmpA  = regWrite && selLow && regAddr[2:0] == REG_CMP_A;
	assign wrCmpB  = regWrite && selLow && regAddr[2:0] == REG_CMP_B;
	assign wrFlags = regWrite && selLow && regAddr[2:0] == REG_FLAGS;

	// Unmapped indices and reserved bits read as zero
	assign rdNext =
		!(regRead && selLow)          ? RST_BYTE :
		regAddr[2:0] == REG_CTRL_A    ? {ctrlA_reg[7:4], 2'b00,
		                                 ctrlA_reg[1:0]} :
		regAddr[2:0] == REG_CTRL_B    ? {4'h0, modeHi_reg, 3'h0} :
		regAddr[2:0] == REG_COUNT     ? count_reg :
		regAddr[2:0] == REG_CMP_A     ? cmpABuf_reg :
		regAddr[2:0] == REG_CMP_B     ? cmpBBuf_reg :
		regAddr[2:0] == REG_FLAGS     ? {5'h00, flags_reg} :
		RST_BYTE;

	// Mode decode
	tpp_mode_t  mode;
	logic       phaseMode;
	logic       fastMode;
	logic       clrMtMode;
	logic       normalMode;
	logic       nonPwm;
	logic [7:0] topValue;
	logic       tick;
	logic       atTop;
	logic       atBottom;
	logic       ovfEvt;
	logic [1:0] matchHit;

	assign mode = tpp_mode_t'({modeHi_reg, ctrlA_reg[1:0]});
	assign phaseMode  = mode == MODE_PC_FF || mode == MODE_PC_A;
	assign fastMode   = mode == MODE_FAST_FF || mode == MODE_FAST_A;
	assign clrMtMode  = mode == MODE_CLRMT;
	assign normalMode = mode == MODE_NORMAL;
	assign nonPwm     = clrMtMode || normalMode;
	assign topValue   = (modeHi_reg || clrMtMode) ? cmpAAct_reg
		: TOP_MAX;
	// Tick is an enable on clk, never a clock
	assign tick = timerTick && !wrCount;
	assign atTop = phaseMode && !countDown_reg
		&& count_reg >= topValue && topValue != BOTTOM;
	assign atBottom = fastMode && count_reg == topValue;
	assign ovfEvt = tick && (phaseMode ? (countDown_reg && count_reg == ONE)
		: fastMode ? count_reg == topValue
		: nonPwm && count_reg == TOP_MAX);

	// Counter sequencing; period with TOP 0xFF is 2*255 = 510 ticks
	always_comb begin
		count_next     = count_reg;
		countDown_next = countDown_reg;
		if (wrCount) begin
			count_next = regWdata;
		end else if (tick) begin
			if (phaseMode) begin
				if (atTop) begin
					countDown_next = 1'b1;
					count_next     = topValue - ONE;
				end else if (countDown_reg) begin
					if (count_reg == BOTTOM) begin
						countDown_next = 1'b0;
						count_next     = (topValue == BOTTOM) ? BOTTOM
							: ONE;
					end else begin
						count_next = count_reg - ONE;
					end
				end else begin
					count_next = count_reg + ONE;
				end
			end else if (fastMode || clrMtMode) begin
				countDown_next = 1'b0;
				count_next = (count_reg == topValue) ? BOTTOM
					: count_reg + ONE;
			end else if (normalMode) begin
				countDown_next = 1'b0;
				count_next = count_reg + ONE;
			end
		end
	end

	// Hardware set wins over a write-one clear in the same cycle
	assign flags_next = (flags_reg & ~(wrFlags ? regWdata[2:0] : 3'h0))
		| {matchHit[1], matchHit[0] && !clrMtMode, ovfEvt}
		| {1'b0, matchHit[0] && clrMtMode, 1'b0};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrlA_reg     <= RST_BYTE;
			modeHi_reg    <= 1'b0;
			count_reg     <= RST_BYTE;
			countDown_reg <= 1'b0;
			block_reg     <= 1'b0;
			flags_reg     <= 3'h0;
			rdata_reg     <= RST_BYTE;
			oeA_reg       <= 1'b0;
			oeB_reg       <= 1'b0;
		end else begin
			if (wrCtrlA)
				ctrlA_reg <= regWdata;
			if (wrCtrlB)
				modeHi_reg <= regWdata[MODE_HI_POS];
			count_reg     <= count_next;
			countDown_reg <= countDown_next;
			// A count write suppresses the match on the next tick
			if (wrCount)
				block_reg <= 1'b1;
			else if (timerTick)
				block_reg <= 1'b0;
			flags_reg <= flags_next;
			rdata_reg <= rdNext;
			oeA_reg   <= overrideA && portDirA;
			oeB_reg   <= overrideB && portDirB;
		end
	end

	// Compare double buffering
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmpABuf_reg <= RST_BYTE;
			cmpBBuf_reg <= RST_BYTE;
			cmpAAct_reg <= RST_BYTE;
			cmpBAct_reg <= RST_BYTE;
		end else begin
			if (wrCmpA)
				cmpABuf_reg <= regWdata;
			if (wrCmpB)
				cmpBBuf_reg <= regWdata;
			if (nonPwm || (tick && (atTop || atBottom))) begin
				cmpAAct_reg <= cmpABuf_reg;
				cmpBAct_reg <= cmpBBuf_reg;
			end
		end
	end

	// Two channels; only channel A offers the toggle option in PWM modes
	logic [1:0] chanAct [2];
	logic [7:0] chanCmp [2];
	logic [7:0] chanNext [2];
	logic [1:0] chanWave;
	logic [1:0] chanConn;

	assign chanAct[0]  = ctrlA_reg[ACT_A_LSB +: 2];
	assign chanAct[1]  = ctrlA_reg[ACT_B_LSB +: 2];
	assign chanCmp[0]  = cmpAAct_reg;
	assign chanCmp[1]  = cmpBAct_reg;
	assign chanNext[0] = cmpABuf_reg;
	assign chanNext[1] = cmpBBuf_reg;

	for (genvar g = 0; g < 2; g++) begin : gChan
		tpp_cmp_chan #(
			.HAS_TOGGLE (g == 0)
		) uChan (
			.clk        (clk),
			.reset_n    (reset_n),
			.tick       (tick),
			.phaseMode  (phaseMode),
			.fastMode   (fastMode),
			.modeHiBit  (modeHi_reg),
			.blockMatch (block_reg),
			.countDown  (countDown_reg),
			.atTop      (atTop),
			.atBottom   (atBottom),
			.action     (chanAct[g]),
			.count      (count_reg),
			.cmpActive  (chanCmp[g]),
			.cmpNext    (chanNext[g]),
			.topValue   (topValue),
			.waveOut    (chanWave[g]),
			.connected  (chanConn[g]),
			.matchHit   (matchHit[g])
		);
	end

	assign regRdata     = rdata_reg;
	assign waveOutA     = chanWave[0];
	assign waveOutB     = chanWave[1];
	assign overrideA    = chanConn[0];
	assign overrideB    = chanConn[1];
	assign pinOeA       = oeA_reg;
	assign pinOeB       = oeB_reg;
	assign overflowFlag = flags_reg[FLAG_OVF];
	assign matchAFlag   = flags_reg[FLAG_MA];
	assign matchBFlag   = flags_reg[FLAG_MB];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence topReached_s;
		tick && atTop;
	endsequence
	sequence turnedDown_s;
		countDown_reg ##1 1'b1;
	endsequence

	topTurn_a: assert property (topReached_s |=>
		countDown_reg && count_reg == $past(topValue) - ONE)
		else $error("counter did not reverse after top");
	topHold_a: assert property (tick && phaseMode && !countDown_reg &&
		count_reg == topValue - ONE && topValue > ONE && !block_reg
		##1 tick [*2] |=> turnedDown_s)
		else $error("top not held for a single tick");
	topFixed_a: assert property (phaseMode && !modeHi_reg |->
		topValue == TOP_MAX)
		else $error("phase mode top is not 0xFF");
	topCmpA_a: assert property (phaseMode && modeHi_reg |->
		topValue == cmpAAct_reg)
		else $error("phase mode top is not compare A");
	ovfSet_a: assert property (tick && phaseMode && countDown_reg &&
		count_reg == ONE |=> overflowFlag && count_reg == BOTTOM)
		else $error("overflow flag not set at bottom");
	ovfWins_a: assert property (ovfEvt && wrFlags &&
		regWdata[FLAG_OVF] |=> overflowFlag)
		else $error("flag clear beat a new overflow");
	tickOnly_a: assert property (!timerTick && !wrCount |=>
		count_reg == $past(count_reg))
		else $error("counter moved without tick");
	bufHold_a: assert property (phaseMode && !(tick && atTop) |=>
		cmpAAct_reg == $past(cmpAAct_reg))
		else $error("active compare changed away from top");
endmodule
`default_nettype wire

// File: core/tpp_pkg.sv
// Shared constants and types for the 8-bit phase-correct PWM timer core
`default_nettype none
package tpp_pkg;
	// Register indices on the plain register port
	localparam logic [2:0] REG_CTRL_A  = 3'h0;
	localparam logic [2:0] REG_CTRL_B  = 3'h1;
	localparam logic [2:0] REG_COUNT   = 3'h2;
	localparam logic [2:0] REG_CMP_A   = 3'h3;
	localparam logic [2:0] REG_CMP_B   = 3'h4;
	localparam logic [2:0] REG_FLAGS   = 3'h5;
	// Field positions
	localparam int ACT_A_LSB   = 6;
	localparam int ACT_B_LSB   = 4;
	localparam int MODE_LO_LSB = 0;
	localparam int MODE_HI_POS = 3;
	localparam int FLAG_OVF    = 0;
	localparam int FLAG_MA     = 1;
	localparam int FLAG_MB     = 2;
	// Values after reset
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_ACT  = 2'h0;
	// Count landmarks
	localparam logic [7:0] TOP_MAX = 8'hFF;
	localparam logic [7:0] BOTTOM  = 8'h00;
	localparam logic [7:0] ONE     = 8'h01;

	typedef enum logic [2:0] {
		MODE_NORMAL = 3'b000,
		MODE_PC_FF  = 3'b001,
		MODE_CLRMT  = 3'b010,
		MODE_FAST_FF = 3'b011,
		MODE_RSV4   = 3'b100,
		MODE_PC_A   = 3'b101,
		MODE_RSV6   = 3'b110,
		MODE_FAST_A = 3'b111
	} tpp_mode_t;

	typedef enum logic [1:0] {
		ACT_OFF    = 2'b00,
		ACT_TOGGLE = 2'b01,
		ACT_CLEAR  = 2'b10,
		ACT_SET    = 2'b11
	} tpp_act_t;
endpackage
`default_nettype wire

// File: core/tpp_cmp_chan.sv
// One compare-output channel: match detect and waveform level
`default_nettype none
module tpp_cmp_chan #(
	parameter bit HAS_TOGGLE = 1'b1
) (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       tick,
	input  wire logic       phaseMode,
	input  wire logic       fastMode,
	input  wire logic       modeHiBit,
	input  wire logic       blockMatch,
	input  wire logic       countDown,
	input  wire logic       atTop,
	input  wire logic       atBottom,
	input  wire logic [1:0] action,
	input  wire logic [7:0] count,
	input  wire logic [7:0] cmpActive,
	input  wire logic [7:0] cmpNext,
	input  wire logic [7:0] topValue,
	output logic            waveOut,
	output logic            connected,
	output logic            matchHit
);
	import tpp_pkg::*;

	logic       wave_reg;
	logic       wave_next;
	logic       conn_reg;
	logic [1:0] actHeld_reg;
	logic       pwmMode;
	logic       toggleOk;
	logic       topCase;
	logic       connNext;
	logic       downMatch;
	logic       upHit_reg;
	logic [1:0] topAct;

	assign pwmMode  = phaseMode | fastMode;
	// Plain modes toggle both channels; PWM toggle only on A with hi bit
	assign toggleOk = !pwmMode
		|| (HAS_TOGGLE && modeHiBit);
	assign matchHit = tick && (count == cmpActive) && !blockMatch;
	assign topCase  = action[1] && pwmMode && (cmpActive == topValue);
	assign connNext = (action != ACT_OFF) &&
		!(action == ACT_TOGGLE && !toggleOk);
	// BOTTOM is where the slope turns up, so a match there acts as up
	assign downMatch = countDown && (count != BOTTOM);
	// No up match seen this slope: TOP applies the code now in force
	assign topAct    = upHit_reg ? actHeld_reg : action;

	always_comb begin
		wave_next = wave_reg;
		if (tick && phaseMode && atTop && topAct[1]) begin
			// Level at TOP forced to up-match result, or its inverse when cmpNext equals TOP, keeps symmetry
			if (cmpNext == topValue)
				wave_next = ~topAct[0];
			else
				wave_next = topAct[0];
		end else if (matchHit) begin
			// Raw action used here: a new code acts from this match on
			case (action)
				ACT_TOGGLE: begin
					if (toggleOk)
						wave_next = ~wave_reg;
				end
				ACT_CLEAR, ACT_SET: begin
					if (!topCase) begin
						if (phaseMode)
							wave_next = downMatch ? ~action[0]
								: action[0];
						else
							wave_next = action[0];
					end else if (fastMode) begin
						// Ignored match at TOP: the wrap action still runs
						wave_next = ~action[0];
					end
				end
				default: wave_next = wave_reg;
			endcase
		end else if (tick && fastMode && atBottom && actHeld_reg[1]) begin
			wave_next = ~actHeld_reg[0];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wave_reg    <= 1'b0;
			conn_reg    <= 1'b0;
			actHeld_reg <= RST_ACT;
			upHit_reg   <= 1'b0;
		end else begin
			wave_reg <= wave_next;
			conn_reg <= connNext;
			if (matchHit)
				actHeld_reg <= action;
			else if (tick && atTop && !upHit_reg)
				actHeld_reg <= action;
			if (tick && atTop)
				upHit_reg <= 1'b0;
			else if (matchHit && !downMatch)
				upHit_reg <= 1'b1;
		end
	end

	assign waveOut   = wave_reg;
	assign connected = conn_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	upClear_a: assert property (phaseMode && matchHit && !atTop &&
		action == ACT_CLEAR && !downMatch && !topCase |=> !wave_reg)
		else $error("up-count match did not clear output");
	downSet_a: assert property (phaseMode && matchHit && !atTop &&
		action == ACT_CLEAR && downMatch && !topCase |=> wave_reg)
		else $error("down-count match did not set output");
	fastBottom_a: assert property (tick && fastMode && atBottom &&
		!matchHit && actHeld_reg == ACT_CLEAR |=> wave_reg)
		else $error("fast mode did not set output at bottom");
	noToggle_a: assert property (pwmMode && action == ACT_TOGGLE &&
		(!HAS_TOGGLE || !modeHiBit) |=> !conn_reg)
		else $error("toggle code connected without toggle option");
	offPort_a: assert property ((action == ACT_OFF) |=> !conn_reg)
		else $error("channel connected with action off");
endmodule
`default_nettype wire

// File: testbench/tpp_pin_load.sv
// External load seen by the two waveform pins
`default_nettype none
module tpp_pin_load (
	input  wire logic driveA,
	input  wire logic driveB,
	input  wire logic waveA,
	input  wire logic waveB,
	output logic      pinA,
	output logic      pinB
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pull-down on the load, so an undriven pin never keeps its last level
	assign pinA = driveA ? waveA : 1'b0;
	assign pinB = driveB ? waveB : 1'b0;
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the phase-correct PWM timer
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import tpp_pkg::*;
	logic       clk, reset_n, timerTick, regWrite, regRead;
	logic [2:0] regAddr;
	logic [7:0] regWdata, regRdata;
	logic       portDirA, portDirB, waveOutA, waveOutB, pinA, pinB;
	logic       overrideA, overrideB, pinOeA, pinOeB;
	logic       overflowFlag, matchAFlag, matchBFlag;
	int         num_errors, checks_done;

	tpp_timer DUT (.clk(clk), .reset_n(reset_n), .timerTick(timerTick),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata), .portDirA(portDirA),
		.portDirB(portDirB), .waveOutA(waveOutA), .waveOutB(waveOutB),
		.overrideA(overrideA), .overrideB(overrideB), .pinOeA(pinOeA),
		.pinOeB(pinOeB), .overflowFlag(overflowFlag),
		.matchAFlag(matchAFlag), .matchBFlag(matchBFlag));
	tpp_pin_load load (.driveA(pinOeA), .driveB(pinOeB), .waveA(waveOutA),
		.waveB(waveOutB), .pinA(pinA), .pinB(pinB));

	always #50 clk = ~clk;

	task automatic finish_test;
		$display("Checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		d = regRdata;
	endtask

	task automatic do_reset;
		@(posedge clk);
		reset_n   <= 1'b0;
		timerTick <= 1'b0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
	endtask

	task automatic wait_flag;
		int n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (overflowFlag !== 1'b1 && n < 2000);
		if (n >= 2000) begin
			num_errors++;
			$display("FAIL overflow wait expected 1 seen 0");
			finish_test();
		end
	endtask

	task automatic t_regs;
		logic [7:0] d;
		wr(3'h7, 8'hFF);
		for (int i = 0; i < 8; i++) begin
			rd(i[2:0], d);
			chk("reset read", 16'h0000, 16'(d));
		end
		wr(REG_CTRL_A, 8'hFF);
		rd(REG_CTRL_A, d);
		chk("control_a", 16'h00F3, 16'(d));
		wr(REG_CTRL_B, 8'hFF);
		rd(REG_CTRL_B, d);
		chk("control_b", 16'h0008, 16'(d));
		wr(REG_CTRL_A, 8'h00);
		wr(REG_CTRL_B, 8'h00);
		$display("test regs done");
	endtask

	task automatic t_pins;
		@(posedge clk);
		portDirA <= 1'b0;
		wr(REG_CTRL_A, 8'hA0);
		repeat (3) @(posedge clk);
		#1;
		chk("overrideA", 16'h0001, 16'(overrideA));
		chk("pinOeA", 16'h0000, 16'(pinOeA));
		@(posedge clk);
		portDirA <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("pinOeA", 16'h0001, 16'(pinOeA));
		chk("pinOeB", 16'h0001, 16'(pinOeB));
		$display("test pins done");
	endtask

	task automatic t_period(input logic [7:0] hi, input logic [7:0] cmp,
		input logic [15:0] exp);
		time t0;
		wr(REG_CMP_A, cmp);
		wr(REG_CTRL_B, hi);
		wr(REG_CTRL_A, 8'h01);
		// Early periods may still carry the previous TOP
		for (int i = 0; i < 3; i++) begin
			wait_flag();
			t0 = $time;
			wr(REG_FLAGS, 8'h01);
		end
		wait_flag();
		chk("period", exp, 16'(($time - t0) / 100));
		$display("test period done");
	endtask

	task automatic t_wave;
		logic [1:0]  md [11] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1,
			2'h3, 2'h3, 2'h0, 2'h0, 2'h0};
		logic [7:0]  cv [11] = '{8'h80, 8'h40, 8'h00, 8'hFF, 8'h00, 8'hFF,
			8'h40, 8'h40, 8'h20, 8'h20, 8'h20};
		logic [1:0]  cd [11] = '{2'h2, 2'h3, 2'h2, 2'h2, 2'h3, 2'h3,
			2'h2, 2'h3, 2'h3, 2'h2, 2'h1};
		int          wn [11] = '{510, 510, 510, 510, 510, 510,
			256, 256, 256, 256, 512};
		logic [15:0] ex [11] = '{16'h0100, 16'h017E, 16'h0000, 16'h01FE,
			16'h01FE, 16'h0000, 16'h0041, 16'h00BF, 16'h0100,
			16'h0000, 16'h0100};
		int hA, hB;
		wr(REG_CTRL_B, 8'h00);
		for (int i = 0; i < 11; i++) begin
			wr(REG_CMP_A, cv[i]);
			wr(REG_CMP_B, cv[i]);
			wr(REG_CTRL_A, {cd[i], cd[i], 2'b00, md[i]});
			repeat (3 * wn[i]) @(posedge clk);
			hA = 0;
			hB = 0;
			repeat (wn[i]) begin
				@(posedge clk);
				#1;
				hA += int'(pinA);
				hB += int'(pinB);
			end
			chk("highA", ex[i], 16'(hA));
			chk("highB", ex[i], 16'(hB));
		end
		$display("test wave done");
	endtask

	task automatic t_toggle;
		int n = 0;
		logic last;
		wr(REG_CMP_A, 8'h10);
		wr(REG_CTRL_B, 8'h08);
		wr(REG_CTRL_A, 8'h51);
		repeat (200) @(posedge clk);
		#1;
		chk("overrideA", 16'h0001, 16'(overrideA));
		chk("overrideB", 16'h0000, 16'(overrideB));
		wr(REG_FLAGS, 8'h07);
		#1;
		last = pinA;
		repeat (320) begin
			@(posedge clk);
			#1;
			if (pinA !== last) n++;
			last = pinA;
		end
		chk("toggles", 16'h000A, 16'(n));
		chk("matchAFlag", 16'h0001, 16'(matchAFlag));
		chk("matchBFlag", 16'h0000, 16'(matchBFlag));
		wr(REG_CTRL_B, 8'h00);
		repeat (3) @(posedge clk);
		#1;
		chk("overrideA", 16'h0000, 16'(overrideA));
		$display("test toggle done");
	endtask

	task automatic t_missed;
		logic [7:0] d;
		do_reset();
		wr(REG_CMP_A, 8'h10);
		wr(REG_CTRL_A, 8'hC1);
		wr(REG_COUNT, 8'h80);
		// Start above compare: the up-count match never happens
		@(posedge clk);
		timerTick <= 1'b1;
		repeat (129) @(posedge clk);
		timerTick <= 1'b0;
		rd(REG_COUNT, d);
		chk("count", 16'h00FD, 16'(d));
		repeat (5) @(posedge clk);
		rd(REG_COUNT, d);
		chk("count held", 16'h00FD, 16'(d));
		chk("waveOutA", 16'h0001, 16'(waveOutA));
		chk("overflowFlag", 16'h0000, 16'(overflowFlag));
		$display("test missed match done");
	endtask

	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		timerTick = 1'b0;
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 3'h0;
		regWdata = 8'h00;
		portDirA = 1'b1;
		portDirB = 1'b1;
		num_errors = 0;
		checks_done = 0;
		do_reset();
		t_regs();
		t_pins();
		@(posedge clk);
		timerTick <= 1'b1;
		t_period(8'h00, 8'h80, 16'h01FE);
		t_period(8'h08, 8'h10, 16'h0020);
		t_wave();
		t_toggle();
		t_missed();
		finish_test();
	end
endmodule
`default_nettype wire
